//--- cps_pkg.sv
`default_nettype none
package cps_pkg;
  localparam int unsigned CPS_DATA_W = 32;
  localparam int unsigned CPS_BE_W = 4;
  localparam int unsigned CPS_LANE_W = 8;
  // dword address covering a 64 MB window
  localparam int unsigned CPS_ADDR_W = 24;
  // only the low words are backed by storage
  localparam int unsigned CPS_STORE_AW = 6;
  localparam int unsigned CPS_STORE_DEPTH = 64;
  localparam logic [CPS_DATA_W-1:0] CPS_DATA_RST = 32'h0000_0000;
  localparam logic [CPS_BE_W-1:0] CPS_BE_FULL = 4'hf;
  localparam logic [CPS_ADDR_W-1:0] CPS_SHADOW_ADDR = 24'h00_0000;

  typedef enum logic [1:0] {
    CPS_IDLE  = 2'b00,
    CPS_WRITE = 2'b01,
    CPS_RESP  = 2'b10
  } cps_state_t;
endpackage : cps_pkg
`default_nettype wire

//--- cps_word_store.sv
`default_nettype none
module cps_word_store
  import cps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic hit,
  input wire logic [CPS_STORE_AW-1:0] index,
  input wire logic [CPS_BE_W-1:0] byteEn,
  input wire logic [CPS_DATA_W-1:0] wrData,
  output logic [CPS_DATA_W-1:0] rdData
);

  wire [CPS_DATA_W-1:0] laneRd;
  logic [CPS_DATA_W-1:0] next_rdData;

  ////////////////////////////////////////////////////////////////////////////
  // one array per lane so every lane has a single writer;
  // unmapped words swallow writes silently
  for (genvar b = 0; b < CPS_BE_W; b++) begin : g_lane
    logic [CPS_LANE_W-1:0] mem [CPS_STORE_DEPTH];
    always_ff @(posedge mclk) begin
      if (wrEn && hit && byteEn[b]) begin
        mem[index] <= wrData[b*CPS_LANE_W +: CPS_LANE_W];
      end
    end
    // disabled or unmapped lanes read as zero
    assign laneRd[b*CPS_LANE_W +: CPS_LANE_W] =
      (hit && byteEn[b]) ? mem[index] : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data registered, so the output stays a flop
  always_comb begin
    next_rdData = rdData;
    if (rdEn) begin
      next_rdData = laneRd;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= CPS_DATA_RST;
    end else begin
      rdData <= next_rdData;
    end
  end
endmodule : cps_word_store
`default_nettype wire

//--- cps_control_slave.sv
// Overview of operation
// - one 32-bit data bus each direction
// - byte enables select bytes, slave honours them
// - address counts 32-bit words, not bytes
// - request consumed when valid and take high
// - response completes when valid and take high
// - read accepted only with its response taken
`default_nettype none
module cps_control_slave
  import cps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctlReset,
  input wire logic reqValid,
  input wire logic reqIsRead,
  input wire logic [CPS_ADDR_W-1:0] reqAddr,
  input wire logic [CPS_BE_W-1:0] reqByteEn,
  input wire logic [CPS_DATA_W-1:0] reqWData,
  output logic reqTake,
  output logic rspValid,
  output logic [CPS_DATA_W-1:0] rspData,
  input wire logic rspTake
);

  cps_state_t state, next_state;
  logic wrTake, next_wrTake;
  logic next_rspValid;
  logic storeWr, storeRd, storeHit;

  ////////////////////////////////////////////////////////////////////////////
  // address decode: consecutive values are consecutive words
  assign storeHit = (reqAddr[CPS_ADDR_W-1:CPS_STORE_AW] == '0);

  ////////////////////////////////////////////////////////////////////////////
  // request / response sequencing
  // ctlReset is the master's synchronous reset, already on mclk
  // one request in flight; reqValid is ignored outside idle
  always_comb begin
    next_state = state;
    next_wrTake = 1'b0;
    next_rspValid = rspValid;
    storeWr = 1'b0;
    storeRd = 1'b0;
    if (ctlReset) begin
      next_state = CPS_IDLE;
      next_rspValid = 1'b0;
    end else begin
      unique case (state)
        CPS_IDLE: begin
          if (reqValid && reqIsRead) begin
            // word read now so data stands with rspValid
            storeRd = 1'b1;
            next_state = CPS_RESP;
            next_rspValid = 1'b1;
          end else if (reqValid) begin
            next_state = CPS_WRITE;
            next_wrTake = 1'b1;
          end
        end
        CPS_WRITE: begin
          // fields still held because the take is only now visible
          storeWr = 1'b1;
          next_state = CPS_IDLE;
        end
        CPS_RESP: begin
          if (rspTake) begin
            next_state = CPS_IDLE;
            next_rspValid = 1'b0;
          end
        end
        default: begin
          next_state = CPS_IDLE;
          next_rspValid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CPS_IDLE;
      wrTake <= 1'b0;
      rspValid <= 1'b0;
    end else begin
      state <= next_state;
      wrTake <= next_wrTake;
      rspValid <= next_rspValid;
    end
  end

  // a read is taken in the very cycle its response is taken;
  // this term cannot come from a flop without breaking that pairing
  assign reqTake = wrTake || (rspValid && rspTake);

  ////////////////////////////////////////////////////////////////////////////
  // backing words, full 32-bit data path
  cps_word_store u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrEn(storeWr),
    .rdEn(storeRd),
    .hit(storeHit),
    .index(reqAddr[CPS_STORE_AW-1:0]),
    .byteEn(reqByteEn),
    .wrData(reqWData),
    .rdData(rspData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper: mirror of word zero, only for checking
  // kept apart from the store so a broken lane write cannot hide itself
  logic [CPS_DATA_W-1:0] shadow, next_shadow;
  logic shadowValid, next_shadowValid;
  logic [CPS_BE_W-1:0] rdDone;

  always_comb begin
    next_shadow = shadow;
    next_shadowValid = shadowValid;
    if (storeWr && reqAddr == CPS_SHADOW_ADDR) begin
      for (int b = 0; b < CPS_BE_W; b++) begin
        if (reqByteEn[b]) begin
          next_shadow[b*CPS_LANE_W +: CPS_LANE_W] =
            reqWData[b*CPS_LANE_W +: CPS_LANE_W];
        end
      end
      if (reqByteEn == CPS_BE_FULL) begin
        next_shadowValid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= CPS_DATA_RST;
      shadowValid <= 1'b0;
    end else begin
      shadow <= next_shadow;
      shadowValid <= next_shadowValid;
    end
  end

  assign rdDone = reqByteEn;

  // checks on what this block drives, all on mclk
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || ctlReset);

  a_read_take_pair:
    assert property (reqTake && reqIsRead |-> rspValid && rspTake)
    else $error("read request taken without its response");

  a_resp_take_pair:
    assert property (rspValid && rspTake |-> reqTake)
    else $error("response taken but read request not taken");

  a_write_take_time:
    assert property (state == CPS_IDLE && reqValid && !reqIsRead
                     |=> reqTake ##1 !reqTake)
    else $error("write not taken for exactly one cycle");

  a_read_resp_time:
    assert property (state == CPS_IDLE && reqValid && reqIsRead
                     |-> !rspValid ##1 rspValid)
    else $error("read response not raised one cycle after request");

  a_resp_holds:
    assert property (rspValid && !rspTake && !ctlReset
                     |=> rspValid && $stable(rspData))
    else $error("response dropped or changed before taken");

  // every lane, not only the low one
  for (genvar b = 0; b < CPS_BE_W; b++) begin : g_lane_chk
    a_lane_masked:
      assert property (@(posedge mclk) disable iff (!rst_n || ctlReset)
                       rspValid && !rdDone[b]
                       |-> rspData[b*CPS_LANE_W +: CPS_LANE_W] == '0)
      else $error("disabled byte lane returned data");
  end

  a_unmapped_zero:
    assert property (rspValid && !storeHit |-> rspData == CPS_DATA_RST)
    else $error("unmapped word returned data");

  a_full_word:
    assert property (rspValid && shadowValid && reqByteEn == CPS_BE_FULL
                     && reqAddr == CPS_SHADOW_ADDR |-> rspData == shadow)
    else $error("word zero read back wrong");

  a_take_one_cycle:
    assert property (reqTake |=> !reqTake)
    else $error("request take held longer than one cycle");

  a_take_on_write:
    assert property (state == CPS_WRITE |-> reqTake)
    else $error("write state without request take");

  a_no_early_take:
    assert property (reqValid && reqIsRead && !rspValid |-> !reqTake)
    else $error("read request taken before its response");

  a_resp_clears:
    assert property (rspValid && rspTake |=> !rspValid)
    else $error("response still valid after it was taken");

  a_write_silent:
    assert property (state == CPS_IDLE && reqValid && !reqIsRead
                     |=> !rspValid)
    else $error("write raised a read response");

  // main scenarios
  c_write: cover property (reqTake && !reqIsRead);
  c_unmapped: cover property (rspValid && !storeHit);
  c_read: cover property (rspValid && rspTake);
  c_read_stall: cover property (rspValid && !rspTake ##1 rspTake);
  c_back_to_back:
    cover property (rspValid && rspTake ##1 reqValid && reqIsRead);
endmodule : cps_control_slave
`default_nettype wire

//--- cps_master_model.sv
`default_nettype none
module cps_master_model
  import cps_pkg::*;
(
  input wire logic mclk,
  input wire logic clr,
  input wire logic go,
  input wire logic isRead,
  input wire logic [CPS_ADDR_W-1:0] addr,
  input wire logic [CPS_BE_W-1:0] be,
  input wire logic [CPS_DATA_W-1:0] wdata,
  input wire logic [3:0] lag,
  input wire logic reqTake,
  input wire logic rspValid,
  input wire logic [CPS_DATA_W-1:0] rspData,
  output logic reqValid,
  output logic reqIsRead,
  output logic [CPS_ADDR_W-1:0] reqAddr,
  output logic [CPS_BE_W-1:0] reqByteEn,
  output logic [CPS_DATA_W-1:0] reqWData,
  output logic rspTake,
  output logic busy,
  output logic [CPS_DATA_W-1:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;
  initial {reqValid, reqIsRead, reqAddr, reqByteEn, reqWData} = '0;
  initial {rspTake, busy, rdData, waitCnt} = '0;
  //////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (clr) begin
      {reqValid, rspTake, busy, waitCnt} <= '0;
    end else begin
      if (go && !busy) begin
        {busy, reqValid, reqIsRead} <= {2'b11, isRead};
        {reqAddr, reqByteEn, reqWData} <= {addr, be, wdata};
      end else if (reqValid && reqTake) begin
        // fields held until taken, then scrambled so stale values show
        {busy, reqValid} <= 2'b00;
        {reqAddr, reqByteEn, reqWData} <= ~{reqAddr, reqByteEn, reqWData};
      end
      // response taken without waiting for reqTake
      if (rspValid && rspTake) begin
        {rspTake, rdData, waitCnt} <= {1'b0, rspData, 4'h0};
      end else if (rspValid && waitCnt == lag) begin
        rspTake <= 1'b1;
      end else if (rspValid) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : cps_master_model
`default_nettype wire

//--- control_plane_slave_port_tb_top.sv
`default_nettype none
module control_plane_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cps_pkg::*;
  logic mclk = 0, rst_n = 0, ctlReset = 0, go = 0, isRead = 0;
  logic reqValid, reqIsRead, reqTake, rspValid, rspTake, busy;
  logic [3:0] lag = 4'h0;
  logic [CPS_ADDR_W-1:0] addr = '0, reqAddr;
  logic [CPS_BE_W-1:0] be = '0, reqByteEn;
  logic [CPS_DATA_W-1:0] wdata = '0, reqWData, rspData, rdData;
  int errors = 0, tests_run = 0;
  always #25 mclk = ~mclk;
  cps_control_slave u_cps_control_slave (.mclk(mclk), .rst_n(rst_n),
    .ctlReset(ctlReset), .reqValid(reqValid), .reqIsRead(reqIsRead),
    .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqWData(reqWData),
    .reqTake(reqTake), .rspValid(rspValid), .rspData(rspData),
    .rspTake(rspTake));
  cps_master_model u_cps_master_model (.mclk(mclk), .clr(ctlReset),
    .go(go), .isRead(isRead), .addr(addr), .be(be), .wdata(wdata),
    .lag(lag), .reqTake(reqTake), .rspValid(rspValid), .rspData(rspData),
    .reqValid(reqValid), .reqIsRead(reqIsRead), .reqAddr(reqAddr),
    .reqByteEn(reqByteEn), .reqWData(reqWData), .rspTake(rspTake),
    .busy(busy), .rdData(rdData));
  //////////////////////////////////////////////////////////////////////
  task results;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task op(logic rd, logic [23:0] a, logic [3:0] b, logic [31:0] d,
      logic [3:0] lg);
    @(posedge mclk);
    {go, isRead, addr, be, wdata, lag} <= {1'b1, rd, a, b, d, lg};
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      #1;
      if (busy === 1'b0) return;
    end
    errors++;
    results();
  endtask : op
  // a read is never accepted apart from its response
  always @(negedge mclk) begin
    if (reqValid === 1'b1 && reqIsRead === 1'b1)
      chk("rdTake", reqTake, rspValid & rspTake);
  end
  task t_word;
    op(1'b0, 24'h1, 4'hf, 32'h1122_3344, 4'h0);
    op(1'b0, 24'h2, 4'hf, 32'h5566_7788, 4'h0);
    op(1'b1, 24'h1, 4'hf, 32'h0, 4'h0);
    chk("word1", rdData, 32'h1122_3344);
    op(1'b1, 24'h2, 4'hf, 32'h0, 4'h3);
    chk("word2", rdData, 32'h5566_7788);
  endtask : t_word
  task t_bytes;
    op(1'b0, 24'h3, 4'hf, 32'hffff_ffff, 4'h0);
    op(1'b0, 24'h3, 4'h5, 32'h0, 4'h0);
    op(1'b1, 24'h3, 4'hf, 32'h0, 4'h0);
    chk("bytes", rdData, 32'hff00_ff00);
    op(1'b1, 24'h3, 4'hc, 32'h0, 4'h1);
    chk("half", rdData, 32'hff00_0000);
  endtask : t_bytes
  task t_split;
    // one 64-bit value sent as two word accesses, low word first
    op(1'b0, 24'h4, 4'hf, 32'h89ab_cdef, 4'h0);
    op(1'b0, 24'h5, 4'hf, 32'h0123_4567, 4'h0);
    op(1'b1, 24'h4, 4'hf, 32'h0, 4'h8);
    chk("lo", rdData, 32'h89ab_cdef);
    op(1'b1, 24'h5, 4'hf, 32'h0, 4'h8);
    chk("hi", rdData, 32'h0123_4567);
  endtask : t_split
  task t_unmapped;
    op(1'b0, 24'h0, 4'hf, 32'h5, 4'h0);
    op(1'b0, 24'h40, 4'hf, 32'habcd, 4'h0);
    op(1'b1, 24'h40, 4'hf, 32'h0, 4'h0);
    chk("unmap", rdData, 32'h0);
    op(1'b1, 24'h0, 4'hf, 32'h0, 4'h0);
    chk("alias", rdData, 32'h5);
  endtask : t_unmapped
  task t_reset;
    @(posedge mclk);
    {go, isRead, addr, be, lag} <= {2'b11, 24'h1, 4'hf, 4'hf};
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("pend", rspValid, 1'b1);
    @(posedge mclk);
    ctlReset <= 1'b1;
    @(posedge mclk);
    ctlReset <= 1'b0;
    #1;
    chk("ctlRst", rspValid, 1'b0);
    op(1'b1, 24'h1, 4'hf, 32'h0, 4'h0);
    chk("after", rdData, 32'h1122_3344);
  endtask : t_reset
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("rstDat", rspData, CPS_DATA_RST);
    chk("rstOut", {reqTake, rspValid}, 2'b00);
    t_word();
    t_bytes();
    t_split();
    t_unmapped();
    t_reset();
    results();
  end
endmodule : control_plane_slave_port_tb_top
`default_nettype wire
